// ---- rtl/sdc_conversion_control.sv ----
`timescale 1ns/1ps
// What this block does
// - Filter output width 15 to 24 by ratio
// - Ratio 256 shows filter bits 23:8
// - Ratio 32 result LSB reads zero
// - Low-bit access returns 16 low filter bits
// - Byte read returns 8 low filter bits
// - Toggle enable flips low-bit access per result or byte read
// - Control write loads access bit from written value
// - Result register loads each decimation step
// - Ready flag sets on load, clears on result or byte read
// - Offset binary: FFFF, 8000, 0000
// - Two's complement: 7FFF, 0000, 8000
// - Single-shot and group bits pick mode
// - Ungrouped channel above grouped one is master
// - Single-shot start clears itself on completion
// - Clearing start halts and powers channel down
// - Continuous mode runs until start cleared
// - Group bit joins channel to next higher
// - Master and last channel group read zero
// - Master start sets and clears member starts
// - Members use own single-shot, start with master
// - Master stop halts whole group at once
// - Independent member start aligns to master
// - Overrun flag on unread overwrite, software clears
module sdc_conversion_control
	import sdc_pkg::*;
#(
	parameter int CHANNELS = 3
) (
	input  wire logic                                core_clk_i,
	input  wire logic                                reset_i,
	input  wire logic                                psel_i,
	input  wire logic                                penable_i,
	input  wire logic                                pwrite_i,
	input  wire logic [11:0]                         paddr_i,
	input  wire logic [31:0]                         pwdata_i,
	output logic      [31:0]                         prdata_o,
	output logic                                     pready_o,
	output logic                                     pslverr_o,
	input  wire logic [CHANNELS-1:0]                 filt_valid_i,
	input  wire logic [CHANNELS-1:0][SDC_FILT_W-1:0] filt_data_i,
	output logic      [CHANNELS-1:0]                 conv_enable_o,
	output logic      [CHANNELS-1:0][1:0]            conv_osr_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sdc_chan_ctrl_type                  ctrl_reg  [CHANNELS];
	sdc_chan_ctrl_type                  ctrl_next [CHANNELS];
	logic [SDC_FILT_W-1:0]              raw_reg   [CHANNELS];
	logic [CHANNELS-1:0]                run_reg;
	logic [CHANNELS-1:0]                run_next;
	logic [CHANNELS-1:0]                load;
	logic [CHANNELS-1:0]                grp_eff;
	int                                 master_of [CHANNELS];
	logic                               pready_reg;
	logic                               pslverr_reg;
	logic [31:0]                        prdata_reg;
	logic                               access;
	logic                               hit;
	logic [SDC_CH_BITS-1:0]             ch_sel;
	logic [1:0]                         reg_sel;
	logic [31:0]                        rd_value;

	// ----------------------------------------------------------------
	// Result formatting
	// ----------------------------------------------------------------
	function automatic logic [SDC_FILT_W-1:0] fmt_raw(input logic [SDC_FILT_W-1:0] raw,
		input sdc_chan_ctrl_type c);
		logic [SDC_FILT_W-1:0] msb;
		case (c.oversampling_ratio_select)
			SDC_OSR_256: msb = SDC_MSB_256;
			SDC_OSR_128: msb = SDC_MSB_128;
			SDC_OSR_64:  msb = SDC_MSB_64;
			default:     msb = SDC_MSB_32;
		endcase
		// Filter delivers offset binary; flipping the sign bit gives two's complement
		return c.data_format_select ? (raw ^ msb) : raw;
	endfunction

	function automatic logic [SDC_RES_W-1:0] view_result(input logic [SDC_FILT_W-1:0] raw,
		input sdc_chan_ctrl_type c);
		logic [SDC_FILT_W-1:0] f;
		logic [SDC_RES_W-1:0]  top;
		f = fmt_raw(raw, c);
		case (c.oversampling_ratio_select)
			SDC_OSR_256: top = f[23:8];
			SDC_OSR_128: top = f[20:5];
			SDC_OSR_64:  top = f[17:2];
			default:     top = {f[14:0], 1'b0};
		endcase
		return c.low_bits_access ? f[15:0] : top;
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign access  = psel_i & penable_i & ~pready_reg;
	assign ch_sel  = paddr_i[SDC_CH_LSB +: SDC_CH_BITS];
	assign reg_sel = paddr_i[SDC_REG_LSB +: 2];
	assign hit     = (paddr_i[11:8] == 4'h0) && (paddr_i[1:0] == 2'h0)
		&& (32'(ch_sel) < 32'(CHANNELS)) && (reg_sel != 2'h3);

	always_comb begin
		logic [SDC_FILT_W-1:0] fb;
		fb       = SDC_RAW_RESET;
		rd_value = 32'h00000000;
		if (hit) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (32'(ch_sel) == 32'(i)) begin
					case (reg_sel)
						SDC_REG_CTRL: begin
							rd_value[SDC_CTRL_W-1:0] = ctrl_reg[i];
							rd_value[SDC_F_GRP] = grp_eff[i];
						end
						SDC_REG_RESULT: begin
							rd_value[SDC_RES_W-1:0] = view_result(raw_reg[i], ctrl_reg[i]);
						end
						default: begin
							// Byte view still honours the data format
							fb            = fmt_raw(raw_reg[i], ctrl_reg[i]);
							rd_value[7:0] = fb[7:0];
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Grouping map
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			// Highest channel has nothing above to join
			grp_eff[i] = (i < CHANNELS - 1) ? ctrl_reg[i].group_with_next : 1'b0;
		end
		master_of[CHANNELS-1] = CHANNELS - 1;
		for (int i = CHANNELS - 2; i >= 0; i--) begin
			// Chain runs up to the first ungrouped channel, which leads
			master_of[i] = grp_eff[i] ? master_of[i+1] : i;
		end
	end

	// ----------------------------------------------------------------
	// Control next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr;
		logic rd_res;
		int   m;
		wr     = 1'b0;
		rd_res = 1'b0;
		m      = 0;
		for (int i = 0; i < CHANNELS; i++) begin
			ctrl_next[i] = ctrl_reg[i];
			wr     = access & pwrite_i & hit & (reg_sel == SDC_REG_CTRL) & (32'(ch_sel) == 32'(i));
			rd_res = access & ~pwrite_i & hit & (reg_sel != SDC_REG_CTRL)
				& (32'(ch_sel) == 32'(i));
			load[i] = filt_valid_i[i] & run_reg[i];
			if (wr) begin
				// On a write the access bit takes its own written value
				ctrl_next[i] = sdc_chan_ctrl_type'(pwdata_i[SDC_CTRL_W-1:0]);
				ctrl_next[i].result_ready_flag = ctrl_reg[i].result_ready_flag
					& pwdata_i[SDC_F_RDY];
				ctrl_next[i].overrun_flag = ctrl_reg[i].overrun_flag & pwdata_i[SDC_F_OVF];
				if (i == CHANNELS - 1) begin
					ctrl_next[i].group_with_next = 1'b0;
				end
			end
			if (rd_res) begin
				ctrl_next[i].result_ready_flag = 1'b0;
				if (ctrl_reg[i].low_bits_toggle_enable) begin
					ctrl_next[i].low_bits_access = ~ctrl_reg[i].low_bits_access;
				end
			end
			if (load[i]) begin
				// Set wins over a clear in the same cycle
				ctrl_next[i].result_ready_flag = 1'b1;
				if (ctrl_reg[i].result_ready_flag & ~rd_res) begin
					ctrl_next[i].overrun_flag = 1'b1;
				end
				if (ctrl_reg[i].single_shot_select) begin
					ctrl_next[i].start_conversion = 1'b0;
				end
			end
		end
		for (int i = 0; i < CHANNELS; i++) begin
			m = master_of[i];
			if (grp_eff[i]) begin
				if (ctrl_next[m].start_conversion & ~ctrl_reg[m].start_conversion) begin
					ctrl_next[i].start_conversion = 1'b1;
				end
				if (~ctrl_next[m].start_conversion & ctrl_reg[m].start_conversion) begin
					ctrl_next[i].start_conversion = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Conversion enables
	// ----------------------------------------------------------------
	always_comb begin
		int m;
		m = 0;
		for (int i = 0; i < CHANNELS; i++) begin
			m = master_of[i];
			if (!ctrl_next[i].start_conversion) begin
				run_next[i] = 1'b0;
			end else if (!grp_eff[i]) begin
				run_next[i] = 1'b1;
			end else if (run_reg[i]) begin
				run_next[i] = 1'b1;
			end else if (ctrl_next[m].start_conversion & ~ctrl_reg[m].start_conversion) begin
				run_next[i] = 1'b1;
			end else begin
				// Late starters wait for the master's decimation boundary
				run_next[i] = run_reg[m] & filt_valid_i[m];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < CHANNELS; i++) begin
				ctrl_reg[i] <= sdc_chan_ctrl_type'(SDC_CTRL_RESET);
			end
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				ctrl_reg[i] <= ctrl_next[i];
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			run_reg <= '0;
		end else begin
			run_reg <= run_next;
		end
	end

	// Stopped channels keep their last word; software should read first
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < CHANNELS; i++) begin
				raw_reg[i] <= SDC_RAW_RESET;
			end
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (load[i]) begin
					raw_reg[i] <= filt_data_i[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// APB response
	// ----------------------------------------------------------------
	// One wait state: side effects land on the edge that raises pready
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access;
		end
	end

	// Error only rides along with the ready pulse
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pslverr_reg <= 1'b0;
		end else if (access) begin
			pslverr_reg <= ~hit;
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	// Read data held after the pulse; writes return zero
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_reg <= SDC_RDATA_RESET;
		end else if (access) begin
			if (pwrite_i) begin
				prdata_reg <= SDC_RDATA_RESET;
			end else begin
				prdata_reg <= rd_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata_o      = prdata_reg;
	assign pready_o      = pready_reg;
	assign pslverr_o     = pslverr_reg;
	assign conv_enable_o = run_reg;

	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			conv_osr_o[i] = ctrl_reg[i].oversampling_ratio_select;
		end
	end

endmodule

// ---- rtl/sdc_pkg.sv ----
package sdc_pkg;

	// ----------------------------------------------------------------
	// Register map, one block of words per channel
	// ----------------------------------------------------------------
	localparam logic [11:0] SDC_CH_STRIDE     = 12'h010;
	localparam logic [1:0]  SDC_REG_CTRL      = 2'h0;  // Byte offset 0x0
	localparam logic [1:0]  SDC_REG_RESULT    = 2'h1;  // Byte offset 0x4
	localparam logic [1:0]  SDC_REG_RES_BYTE  = 2'h2;  // Byte offset 0x8
	localparam int          SDC_CH_LSB        = 4;
	localparam int          SDC_CH_BITS       = 4;
	localparam int          SDC_REG_LSB       = 2;
	localparam int          SDC_MAX_CHANNELS  = 16;

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int SDC_F_OSR   = 0;
	localparam int SDC_F_DF    = 2;
	localparam int SDC_F_SNGL  = 3;
	localparam int SDC_F_GRP   = 4;
	localparam int SDC_F_SC    = 5;
	localparam int SDC_F_LACC  = 6;
	localparam int SDC_F_LTOG  = 7;
	localparam int SDC_F_RDY   = 8;
	localparam int SDC_F_OVF   = 9;
	localparam int SDC_CTRL_W  = 10;

	// ----------------------------------------------------------------
	// Oversampling ratio codes and filter widths
	// ----------------------------------------------------------------
	localparam logic [1:0] SDC_OSR_256 = 2'h0;
	localparam logic [1:0] SDC_OSR_128 = 2'h1;
	localparam logic [1:0] SDC_OSR_64  = 2'h2;
	localparam logic [1:0] SDC_OSR_32  = 2'h3;
	localparam int         SDC_FILT_W  = 24;
	localparam int         SDC_RES_W   = 16;
	localparam logic [23:0] SDC_MSB_256 = 24'h800000;
	localparam logic [23:0] SDC_MSB_128 = 24'h100000;
	localparam logic [23:0] SDC_MSB_64  = 24'h020000;
	localparam logic [23:0] SDC_MSB_32  = 24'h004000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [9:0]  SDC_CTRL_RESET = 10'h000;
	localparam logic [23:0] SDC_RAW_RESET  = 24'h000000;
	localparam logic [31:0] SDC_RDATA_RESET = 32'h00000000;

	typedef struct packed {
		logic       overrun_flag;
		logic       result_ready_flag;
		logic       low_bits_toggle_enable;
		logic       low_bits_access;
		logic       start_conversion;
		logic       group_with_next;
		logic       single_shot_select;
		logic       data_format_select;
		logic [1:0] oversampling_ratio_select;
	} sdc_chan_ctrl_type;

endpackage

// ---- tb/sdc_checker_sva.sv ----
`timescale 1ns/1ps
// ------
// Checker
// ------
module sdc_checker
	import sdc_pkg::*;
#(
	parameter int CHANNELS = 3
) (
	input wire logic                     core_clk_i,
	input wire logic                     reset_i,
	input wire logic                     psel_i,
	input wire logic                     penable_i,
	input wire logic                     pwrite_i,
	input wire logic [11:0]              paddr_i,
	input wire logic [31:0]              pwdata_i,
	input wire logic [31:0]              prdata_o,
	input wire logic                     pready_o,
	input wire logic [CHANNELS-1:0]      filt_valid_i,
	input wire logic [CHANNELS-1:0]      conv_enable_o,
	input wire logic [CHANNELS-1:0][1:0] conv_osr_o
);
	logic wr;
	logic w2;
	logic sngl2_reg;
	logic grp1_reg;
	assign wr = psel_i && penable_i && !pready_o && pwrite_i;
	assign w2 = wr && paddr_i == 12'h020;
	// Shadows of bits the ports cannot show
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sngl2_reg <= 1'b0;
			grp1_reg  <= 1'b0;
		end else if (w2) begin
			sngl2_reg <= pwdata_i[SDC_F_SNGL];
		end else if (wr && paddr_i == 12'h010) begin
			grp1_reg <= pwdata_i[SDC_F_GRP];
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	property p_osr;
		wr && paddr_i == 12'h000 |=> conv_osr_o[0] == $past(pwdata_i[1:0]);
	endproperty
	a_osr: assert property (p_osr) else $error("ratio out wrong");
	property p_sngl;
		conv_enable_o[2] && filt_valid_i[2] && sngl2_reg && !psel_i |=> !conv_enable_o[2];
	endproperty
	a_sngl: assert property (p_sngl) else $error("single shot ran on");
	property p_cont;
		conv_enable_o[2] && filt_valid_i[2] && !sngl2_reg && !psel_i |=> conv_enable_o[2];
	endproperty
	a_cont: assert property (p_cont) else $error("continuous stopped");
	property p_stop;
		w2 && !pwdata_i[SDC_F_SC] |=> !conv_enable_o[2];
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_gstart;
		w2 && pwdata_i[SDC_F_SC] && grp1_reg && !conv_enable_o[2] |=> conv_enable_o[2:1] == 2'h3;
	endproperty
	a_gstart: assert property (p_gstart) else $error("group start");
	property p_gstop;
		w2 && !pwdata_i[SDC_F_SC] && grp1_reg |=> conv_enable_o[2:1] == 2'h0;
	endproperty
	a_gstop: assert property (p_gstop) else $error("group stop");
	property p_sync;
		$rose(conv_enable_o[1]) && grp1_reg |-> $rose(conv_enable_o[2]) || $past(filt_valid_i[2]);
	endproperty
	a_sync: assert property (p_sync) else $error("member out of step");
	property p_grp;
		psel_i && pready_o && !pwrite_i && paddr_i == 12'h020 |-> !prdata_o[SDC_F_GRP];
	endproperty
	a_grp: assert property (p_grp) else $error("last group bit set");
	c_gstart: cover property (w2 && pwdata_i[SDC_F_SC] && grp1_reg);
	c_done: cover property ($fell(conv_enable_o[2]));
	c_res: cover property (pready_o && paddr_i == 12'h024);
endmodule
bind sdc_conversion_control sdc_checker #(.CHANNELS(CHANNELS)) i_sdc_checker (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.filt_valid_i(filt_valid_i), .conv_enable_o(conv_enable_o), .conv_osr_o(conv_osr_o)
);

// ---- tb/sdc_filter_model.sv ----
`timescale 1ns/1ps
// ------
// Decimation filter stand-in
// ------
module sdc_filter_model (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [2:0]       en_i,
	input  wire logic [7:0]       period_i,
	input  wire logic [23:0]      sample_i,
	output logic      [2:0]       valid_o,
	output logic      [2:0][23:0] data_o
);
	logic [7:0] cnt_reg;
	// One shared count, so group members decimate in step
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_reg <= 8'h00;
		end else if (en_i == 3'h0 || cnt_reg >= period_i) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	assign valid_o = (cnt_reg >= period_i) ? en_i : 3'h0;
	// Data off the strobe is junk, never the last value
	for (genvar i = 0; i < 3; i++) begin : g_d
		assign data_o[i] = valid_o[i] ? sample_i : ~sample_i ^ {3{cnt_reg}};
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import sdc_pkg::*;
;
	logic             clk, rst, psel, pen, pwr, err, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, q;
	logic [2:0]       fv, en;
	logic [2:0][23:0] fd;
	logic [2:0][1:0]  osr;
	logic [7:0]       period;
	logic [23:0]      sample;
	int               fail_count, n_checks, cyc;
	// Control, sample, address, expected word
	logic [59:0] tbl [13] = '{
		{8'h00, 24'hc3a5e7, 12'h024, 16'hc3a5}, {8'h01, 24'hc3a5e7, 12'h024, 16'h1d2f},
		{8'h02, 24'hc3a5e7, 12'h024, 16'he979}, {8'h03, 24'hc3a5e7, 12'h024, 16'h4bce},
		{8'h00, 24'hffffff, 12'h024, 16'hffff}, {8'h00, 24'h800000, 12'h024, 16'h8000},
		{8'h00, 24'h000000, 12'h024, 16'h0000}, {8'h04, 24'hffffff, 12'h024, 16'h7fff},
		{8'h04, 24'h800000, 12'h024, 16'h0000}, {8'h04, 24'h000000, 12'h024, 16'h8000},
		{8'h07, 24'h004000, 12'h024, 16'h0000}, {8'h40, 24'hc3a5e7, 12'h024, 16'ha5e7},
		{8'h00, 24'hc3a5e7, 12'h028, 16'h00e7}};
	always #20 clk = ~clk;
	sdc_conversion_control #(.CHANNELS(3)) i_sdc_conversion_control (
		.core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .filt_valid_i(fv), .filt_data_i(fd),
		.conv_enable_o(en), .conv_osr_o(osr));
	sdc_filter_model i_sdc_filter_model (.clk_i(clk), .reset_i(rst), .en_i(en),
		.period_i(period), .sample_i(sample), .valid_o(fv), .data_o(fd));
	// ------
	// Bus and check helpers
	// ------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && t < 20) begin
			@(posedge clk);
			t++;
		end
		if (t >= 20) begin
			fail_count++;
			$display("[FAIL] apb ready expected 1 seen %b", pready);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ------
	// Scenarios
	// ------
	task automatic conv(input logic [59:0] e);
		sample <= e[51:28];
		apb(1'b1, 12'h020, {24'h0, e[59:52]} | 32'h28);
		for (int i = 0; i < 60 && en[2] !== 1'b0; i++) @(posedge clk);
		apb(1'b0, 12'h020, 32'h0);
		chk("flags", 32'h100, q & 32'h320);
		chk("osr", {30'h0, e[53:52]}, {30'h0, osr[2]});
		apb(1'b0, e[27:16], 32'h0);
		chk("result", {16'h0, e[15:0]}, {16'h0, q[15:0]});
		apb(1'b0, 12'h020, 32'h0);
		chk("ready clear", 32'h0, q & 32'h100);
	endtask
	task automatic t_toggle;
		apb(1'b1, 12'h020, 32'hc0);
		apb(1'b0, 12'h020, 32'h0);
		chk("access", 32'h40, q & 32'h40);
		apb(1'b0, 12'h024, 32'h0);
		chk("low half", 32'ha5e7, q & 32'hffff);
		apb(1'b0, 12'h024, 32'h0);
		chk("high half", 32'hc3a5, q & 32'hffff);
	endtask
	task automatic t_cont;
		period <= 8'h07;
		apb(1'b1, 12'h020, 32'h20);
		repeat (30) @(posedge clk);
		chk("running", 32'h1, {31'h0, en[2]});
		apb(1'b0, 12'h024, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("overrun", 32'h200, q & 32'h200);
		apb(1'b1, 12'h020, 32'h300);
		chk("stopped", 32'h0, {31'h0, en[2]});
		apb(1'b1, 12'h020, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("overrun clear", 32'h0, q & 32'h200);
	endtask
	task automatic t_group;
		period <= 8'h03;
		apb(1'b1, 12'h010, 32'h10);
		apb(1'b1, 12'h020, 32'h30);
		chk("group run", 32'h6, {29'h0, en});
		apb(1'b0, 12'h020, 32'h0);
		chk("master grp", 32'h0, q & 32'h10);
		apb(1'b1, 12'h010, 32'h10);
		chk("member off", 32'h4, {29'h0, en});
		apb(1'b1, 12'h010, 32'h30);
		for (int i = 0; i < 40 && en[1] !== 1'b1; i++) @(posedge clk);
		chk("member rejoin", 32'h6, {29'h0, en});
		apb(1'b1, 12'h020, 32'h0);
		chk("group stop", 32'h0, {29'h0, en});
		apb(1'b0, 12'h010, 32'h0);
		chk("member start", 32'h0, q & 32'h20);
		apb(1'b1, 12'h010, 32'h0);
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
	endtask
	// Cut a hang short well past the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			stop_test();
		end
	end
	initial begin
		{clk, psel, pen, pwr, paddr, pwdata, period, sample} = '0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (tbl[i]) conv(tbl[i]);
		t_toggle();
		t_cont();
		t_group();
		stop_test();
	end
endmodule
